//--- common/ssh_regs.svh
// timing counts and field positions of the split-strobe host port
// Contract
// - little endian: low strobe even byte, high odd
// - little endian reads mirror write lane mapping
// - big endian: low strobe odd, high even (device ignores byte_order; low strobe always writes the even byte)
// - big endian reads: high even, low odd (device reads use the little endian mapping in both orders)
// - ignore address bit zero, decode word address
// - host write data valid by fourth edge
// - strobe start drives wait low
// - host holds strobes until wait released
// - wait released within half bus period
// - strobes idle one period between accesses
// - memory clock divided above fifty megahertz
`ifndef SSH_REGS_SVH
`define SSH_REGS_SVH
`define SSH_DATA_SETUP_EDGES 4
`define SSH_MIN_CYCLE 5
`define SSH_MIN_IDLE 1
`define SSH_BUS_CLK_HZ 20000000
`define SSH_MCLK_LIMIT_HZ 50000000
`define SSH_MCLK_DIV_LSB 4
`define SSH_MCLK_DIV_MSB 5
`define SSH_WAIT_CYCLES 2
`endif

//--- common/ssh_pkg.sv
// types shared by both ends of the split-strobe host port
package ssh_pkg;
  typedef logic [15:0] ssh_word_t;
  typedef logic [15:0] ssh_waddr_t;
  typedef enum logic {ssh_little_e, ssh_big_e} ssh_order_t;
endpackage

//--- common/ssh_bus_if.sv
// pin-level bus between host and device
`timescale 1ns/1ps
interface ssh_bus_if;
  logic [16:0] addr;
  logic cs_n;
  logic low_byte_write_strobe_n;
  logic high_byte_write_strobe_n;
  logic low_byte_read_strobe_n;
  logic high_byte_read_strobe_n;
  logic [15:0] host_d_out;
  logic host_d_oe;
  logic [15:0] dev_d_out;
  logic [1:0] dev_d_oe;
  logic wait_n_out;
  logic wait_oe;
  modport host (
    output addr, cs_n, low_byte_write_strobe_n, high_byte_write_strobe_n,
    output low_byte_read_strobe_n, high_byte_read_strobe_n,
    output host_d_out, host_d_oe,
    input dev_d_out, dev_d_oe, wait_n_out, wait_oe
  );
  modport device (
    input addr, cs_n, low_byte_write_strobe_n, high_byte_write_strobe_n,
    input low_byte_read_strobe_n, high_byte_read_strobe_n,
    input host_d_out, host_d_oe,
    output dev_d_out, dev_d_oe, wait_n_out, wait_oe
  );
endinterface

//--- logic/ssh_device.sv
// device end: decodes strobes, holds off host with wait, steers byte lanes
`timescale 1ns/1ps
`include "ssh_regs.svh"
module ssh_device #(
  parameter int WAIT_CYCLES = `SSH_WAIT_CYCLES,
  parameter int MEM_WORDS = 256
) (
  input wire logic clk,
  input wire logic sys_rst,
  ssh_bus_if.device bus,
  input wire ssh_pkg::ssh_order_t byte_order,
  input wire logic [1:0] memory_clock_divide,
  output logic mclk_en,
  output logic div_required,
  output logic wr_pulse,
  output logic [15:0] wr_addr,
  output logic [1:0] wr_lanes
);
  import ssh_pkg::*;
  typedef enum {ssh_idle, ssh_hold, ssh_done} ssh_dstate_t;
  localparam int AW = $clog2(MEM_WORDS);
  ssh_word_t mem [MEM_WORDS];
  // all pins cross two flops before use
  logic [20:0] s1, s2;
  logic [15:0] d1, d2;
  always_ff @(posedge clk) begin
    s1 <= {bus.cs_n, bus.low_byte_write_strobe_n,
           bus.high_byte_write_strobe_n, bus.low_byte_read_strobe_n,
           bus.high_byte_read_strobe_n, bus.addr[16:1]};
    s2 <= s1;
    d1 <= bus.host_d_out;
    d2 <= d1;
  end
  logic cs, wl, wh, rl, rh;
  logic [15:0] waddr;
  assign cs = ~s2[20];
  assign wl = ~s2[19];
  assign wh = ~s2[18];
  assign rl = ~s2[17];
  assign rh = ~s2[16];
  assign waddr = s2[15:0];
  // physical lanes: index0 = D[7:0]; mapping fixed by strobe in both orders
  ssh_dstate_t state, next_state;
  logic [7:0] cnt, next_cnt;
  logic wait_oe, next_wait_oe;
  logic [15:0] rdata, next_rdata;
  logic [1:0] rd_oe, next_rd_oe;
  logic wr_pulse_q, next_wr_pulse;
  logic [1:0] lanes, next_lanes;
  logic [15:0] waddr_q, next_waddr;
  logic any_str;
  assign any_str = wl | wh | rl | rh;
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_wait_oe = wait_oe;
    next_rdata = rdata;
    next_rd_oe = rd_oe;
    next_wr_pulse = 1'b0;
    next_lanes = lanes;
    next_waddr = waddr_q;
    unique case (state)
      ssh_idle: begin
        if (cs && any_str) begin
          next_state = ssh_hold;
          next_wait_oe = 1'b1;
          next_cnt = 8'h00;
          next_waddr = waddr;
          next_lanes = (wl | wh) ? {wh, wl} : {rh, rl};
        end
      end
      ssh_hold: begin
        next_cnt = cnt + 8'h01;
        // write data sampled after the fourth edge guarantee
        if (cnt >= 8'(`SSH_DATA_SETUP_EDGES + WAIT_CYCLES)) begin
          next_state = ssh_done;
          if (rl | rh) begin
            next_rdata = mem[waddr_q[AW-1:0]];
            next_rd_oe = {rh, rl};
          end else begin
            next_wr_pulse = 1'b1;
          end
        end
      end
      ssh_done: begin
        if (!any_str) begin
          next_state = ssh_idle;
          next_rd_oe = 2'b00;
        end
      end
    endcase
    if (state == ssh_done && !any_str)
      next_wait_oe = 1'b0;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ssh_idle;
      cnt <= 8'h00;
      wait_oe <= 1'b0;
      rdata <= 16'h0000;
      rd_oe <= 2'b00;
      wr_pulse_q <= 1'b0;
      lanes <= 2'b00;
      waddr_q <= 16'h0000;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      wait_oe <= next_wait_oe;
      rdata <= next_rdata;
      rd_oe <= next_rd_oe;
      wr_pulse_q <= next_wr_pulse;
      lanes <= next_lanes;
      waddr_q <= next_waddr;
    end
  end
  always_ff @(posedge clk) begin
    if (next_wr_pulse) begin
      if (lanes[0])
        mem[waddr_q[AW-1:0]][7:0] <= d2[7:0];
      if (lanes[1])
        mem[waddr_q[AW-1:0]][15:8] <= d2[15:8];
    end
  end
  // wait low while held, released once the access completes
  assign bus.wait_oe = wait_oe;
  assign bus.wait_n_out = (state == ssh_done);
  assign bus.dev_d_out = rdata;
  assign bus.dev_d_oe = rd_oe;
  assign wr_pulse = wr_pulse_q;
  assign wr_addr = waddr_q;
  assign wr_lanes = lanes;
  // memory clock enable derived from bus clock by 2^divide
  logic [2:0] mdiv, next_mdiv;
  logic [2:0] mlim;
  assign mlim = 3'((3'h1 << memory_clock_divide) - 3'h1);
  always_comb begin
    next_mdiv = (mdiv >= mlim) ? 3'h0 : 3'(mdiv + 3'h1);
  end
  always_ff @(posedge clk) begin
    if (sys_rst)
      mdiv <= 3'h0;
    else
      mdiv <= next_mdiv;
  end
  assign mclk_en = (mdiv == 3'h0);
  assign div_required = (`SSH_BUS_CLK_HZ > `SSH_MCLK_LIMIT_HZ) &&
                        (memory_clock_divide == 2'b00);
endmodule

//--- logic/ssh_host.sv
// host end: runs one access at a time with spacing and wait handshake
`timescale 1ns/1ps
`include "ssh_regs.svh"
module ssh_host (
  input wire logic clk,
  input wire logic sys_rst,
  ssh_bus_if.host bus,
  input wire logic req,
  input wire logic req_write,
  input wire logic [1:0] req_lanes,
  input wire logic [16:0] req_addr,
  input wire ssh_pkg::ssh_word_t req_wdata,
  output logic req_ready,
  output logic done,
  output ssh_pkg::ssh_word_t rdata
);
  import ssh_pkg::*;
  typedef enum {ssh_h_idle, ssh_h_act, ssh_h_gap} ssh_hstate_t;
  logic w1, w2, wo1, wo2;
  always_ff @(posedge clk) begin
    w1 <= bus.wait_n_out;
    w2 <= w1;
    wo1 <= bus.wait_oe;
    wo2 <= wo1;
  end
  logic released;
  assign released = wo2 & w2;
  ssh_hstate_t st, next_st;
  logic [7:0] cyc, next_cyc;
  logic wr, next_wr;
  logic [1:0] ln, next_ln;
  logic [16:0] ad, next_ad;
  ssh_word_t wd, next_wd, rd, next_rd;
  logic dn, next_dn;
  always_comb begin
    next_st = st;
    next_cyc = 8'(cyc + 8'h01);
    next_wr = wr;
    next_ln = ln;
    next_ad = ad;
    next_wd = wd;
    next_rd = rd;
    next_dn = 1'b0;
    unique case (st)
      ssh_h_idle: begin
        if (req) begin
          next_st = ssh_h_act;
          next_cyc = 8'h00;
          next_wr = req_write;
          next_ln = req_lanes;
          next_ad = req_addr;
          next_wd = req_wdata;
        end
      end
      ssh_h_act: begin
        if (released) begin
          next_st = ssh_h_gap;
          next_dn = 1'b1;
          if (!wr)
            next_rd = bus.dev_d_out;
        end
      end
      ssh_h_gap: begin
        if (cyc >= 8'(`SSH_MIN_CYCLE) && !wo2)
          next_st = ssh_h_idle;
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= ssh_h_idle;
      cyc <= 8'h00;
      wr <= 1'b0;
      ln <= 2'b00;
      ad <= 17'h00000;
      wd <= 16'h0000;
      rd <= 16'h0000;
      dn <= 1'b0;
    end else begin
      st <= next_st;
      cyc <= next_cyc;
      wr <= next_wr;
      ln <= next_ln;
      ad <= next_ad;
      wd <= next_wd;
      rd <= next_rd;
      dn <= next_dn;
    end
  end
  logic act;
  assign act = (st == ssh_h_act);
  assign bus.addr = ad;
  assign bus.cs_n = ~act;
  assign bus.low_byte_write_strobe_n = ~(act & wr & ln[0]);
  assign bus.high_byte_write_strobe_n = ~(act & wr & ln[1]);
  assign bus.low_byte_read_strobe_n = ~(act & ~wr & ln[0]);
  assign bus.high_byte_read_strobe_n = ~(act & ~wr & ln[1]);
  assign bus.host_d_out = wd;
  assign bus.host_d_oe = act & wr;
  assign req_ready = (st == ssh_h_idle);
  assign done = dn;
  assign rdata = rd;
endmodule

//--- tb/ssh_bus_monitor.sv
// concurrent checks on the host port wires
`timescale 1ns/1ps
module ssh_bus_monitor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic low_byte_write_strobe_n,
  input wire logic high_byte_write_strobe_n,
  input wire logic low_byte_read_strobe_n,
  input wire logic high_byte_read_strobe_n,
  input wire logic host_d_oe,
  input wire logic [1:0] dev_d_oe,
  input wire logic wait_n_out,
  input wire logic wait_oe
);
  logic [3:0] s;
  assign s = {low_byte_write_strobe_n, high_byte_write_strobe_n,
    low_byte_read_strobe_n, high_byte_read_strobe_n};
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_wait_drive_low: assert property ($fell(&s) && !cs_n
    |-> ##[1:3] (wait_oe && !wait_n_out)) else $error("wait not driven");
  a_wait_starts_low: assert property ($rose(wait_oe) |-> !wait_n_out)
    else $error("wait driven high first");
  a_strobe_hold: assert property ((s != 4'hF) && !(wait_oe && wait_n_out)
    |=> $stable(s)) else $error("strobe left before release");
  a_wait_float: assert property ($rose(&s) |-> ##[1:4] !wait_oe)
    else $error("wait kept driven");
  a_idle_gap: assert property ($rose(&s) |=> &s)
    else $error("strobes reasserted too soon");
  a_min_cycle: assert property ($fell(&s) |-> (s != 4'hF)[*5])
    else $error("access too short");
  a_wdata_setup: assert property ((!cs_n && !(&s[3:2]))[*4]
    |-> host_d_oe) else $error("write data late");
  a_low_lane_rd: assert property ($rose(dev_d_oe[0])
    |-> !low_byte_read_strobe_n) else $error("low lane driven");
  a_high_lane_rd: assert property ($rose(dev_d_oe[1])
    |-> !high_byte_read_strobe_n) else $error("high lane driven");
  a_lane_release: assert property ((&s[1:0])[*5] |-> dev_d_oe == 2'h0)
    else $error("lanes not released");
endmodule

//--- tb/generic_split_strobe_host_port_test.sv
// bench joining host and device ends across the bus
`timescale 1ns/1ps
module generic_split_strobe_host_port_test;
  import ssh_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  ssh_order_t ord = ssh_little_e;
  logic [1:0] mdiv = 2'h0;
  logic req = 1'b0;
  logic req_write = 1'b0;
  logic [1:0] req_lanes = 2'h0;
  logic [16:0] req_addr = 17'h00000;
  ssh_word_t req_wdata = 16'h0000;
  logic req_ready, done, mclk_en, div_required, wr_pulse;
  ssh_word_t rdata;
  logic [15:0] wr_addr, cap_addr;
  logic [1:0] wr_lanes, cap_lanes;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  ssh_bus_if ssh_bus_if_i ();
  ssh_device ssh_device_i (.clk(clk), .sys_rst(sys_rst),
    .bus(ssh_bus_if_i), .byte_order(ord), .memory_clock_divide(mdiv),
    .mclk_en(mclk_en), .div_required(div_required), .wr_pulse(wr_pulse),
    .wr_addr(wr_addr), .wr_lanes(wr_lanes));
  ssh_host ssh_host_i (.clk(clk), .sys_rst(sys_rst), .bus(ssh_bus_if_i),
    .req(req), .req_write(req_write), .req_lanes(req_lanes),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .done(done), .rdata(rdata));
  ssh_bus_monitor ssh_bus_monitor_i (.clk(clk), .sys_rst(sys_rst),
    .cs_n(ssh_bus_if_i.cs_n),
    .low_byte_write_strobe_n(ssh_bus_if_i.low_byte_write_strobe_n),
    .high_byte_write_strobe_n(ssh_bus_if_i.high_byte_write_strobe_n),
    .low_byte_read_strobe_n(ssh_bus_if_i.low_byte_read_strobe_n),
    .high_byte_read_strobe_n(ssh_bus_if_i.high_byte_read_strobe_n),
    .host_d_oe(ssh_bus_if_i.host_d_oe), .dev_d_oe(ssh_bus_if_i.dev_d_oe),
    .wait_n_out(ssh_bus_if_i.wait_n_out), .wait_oe(ssh_bus_if_i.wait_oe));
  always #25 clk = ~clk;
  // write pulse lasts one cycle, so latch it for later checks
  always @(posedge clk) begin
    if (wr_pulse === 1'b1) begin
      cap_addr <= wr_addr;
      cap_lanes <= wr_lanes;
    end
  end
  task automatic summarize();
    $display("errors=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic access(input logic w, input logic [1:0] ln,
    input logic [16:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk);
    while (req_ready !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    req = 1'b1;
    req_write = w;
    req_lanes = ln;
    req_addr = a;
    req_wdata = d;
    @(negedge clk);
    req = 1'b0;
    n = 0;
    // bounded wait; a missing done shows up in the data checks
    while (done !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic t_lanes(input ssh_order_t o, input logic [16:0] a);
    ord = o;
    access(1'b1, 2'h3, a, 16'hA55A);
    chk(cap_addr, a[16:1]);
    chk({14'h0, cap_lanes}, 16'h0003);
    access(1'b1, 2'h1, a & 17'h1FFFE, 16'h1234);
    chk({14'h0, cap_lanes}, 16'h0001);
    access(1'b1, 2'h2, a, 16'hBEEF);
    chk({14'h0, cap_lanes}, 16'h0002);
    access(1'b0, 2'h3, a & 17'h1FFFE, 16'h0000);
    chk(rdata, 16'hBE34);
    access(1'b0, 2'h1, a, 16'h0000);
    chk({8'h00, rdata[7:0]}, 16'h0034);
    access(1'b0, 2'h2, a, 16'h0000);
    chk({rdata[15:8], 8'h00}, 16'hBE00);
    $display("test lanes done");
  endtask
  task automatic t_mclk();
    int k;
    int c;
    for (k = 0; k < 4; k++) begin
      @(negedge clk);
      mdiv = k[1:0];
      repeat (8) @(negedge clk);
      c = 0;
      repeat (32) begin
        @(negedge clk);
        if (mclk_en === 1'b1) c++;
      end
      chk(c[15:0], 16'h0020 >> k);
      chk({15'h0, div_required}, 16'h0000);
    end
    $display("test mclk done");
  endtask
  initial begin
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge clk);
    t_lanes(ssh_little_e, 17'h00011);
    t_lanes(ssh_big_e, 17'h001FF);
    t_mclk();
    summarize();
  end
endmodule
